// ### hdl/twe_regs.vh
// Constants for the two-wire serial memory slave interface.
`ifndef TWE_REGS_VH
`define TWE_REGS_VH

// Clock rate and self-timed program cycle.
`define TWE_CLK_MHZ        100
`define TWE_PROG_TIME_MS   6
`define TWE_PROG_CYCLES    (`TWE_PROG_TIME_MS * `TWE_CLK_MHZ * 1000)

// Array address layout.
`define TWE_ADDR_W         14
`define TWE_ADDR_HI_BITS   6
`define TWE_ADDR_ONE       14'h0001

// Slave address byte fields.
`define TWE_TYPE_MSB       7
`define TWE_TYPE_LSB       4
`define TWE_SEL_MSB        3
`define TWE_SEL_LSB        1
`define TWE_RW_BIT         0

// Byte position within a transfer.
`define TWE_BYTE_SLAVE     2'h0
`define TWE_BYTE_ADDR_HI   2'h1
`define TWE_BYTE_ADDR_LO   2'h2
`define TWE_BYTE_DATA      2'h3

// Bits per byte and write FIFO depth.
`define TWE_BITS_PER_BYTE  4'h8
`define TWE_LAST_TX_BIT    4'h7
`define TWE_FIFO_DEPTH     4

`endif

// ### hdl/twe_sync.v
// Two-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/1ns
module twe_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // Pins and synchronised copies
  input  wire [WIDTH-1:0] pin,
  output wire [WIDTH-1:0] sync
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
    end
  end

  assign sync = sync_ff;

endmodule

// ### hdl/twe_fifo.v
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module twe_fifo #(
  parameter WIDTH = 22,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data  = mem_ff[rd_ptr_ff];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_entry
      localparam [AW-1:0] IDX = gi;
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          mem_ff[gi] <= {WIDTH{1'b0}};
        end else if (push && (wr_ptr_ff == IDX)) begin
          mem_ff[gi] <= in_data;
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule

// ### hdl/twe_slave.v
// Two-wire serial memory slave: bus protocol, write buffering and program timer.
`timescale 1ns/1ns
`include "twe_regs.vh"
module twe_slave #(
  parameter [3:0] TYPE_CODE   = 4'h5, // Arbitrary type code.
  parameter       PROG_CYCLES = `TWE_PROG_CYCLES,
  parameter       FIFO_DEPTH  = `TWE_FIFO_DEPTH,
  parameter       FIFO_AW     = 2
) (
  // Clock and reset
  input  wire                   clk,
  input  wire                   arst_n,
  // Two-wire bus pins
  input  wire                   scl,
  input  wire                   sda_in,
  output wire                   sda_out,
  output wire                   sda_oe,
  // Strap and protect pins
  input  wire                   chip_select_bit0,
  input  wire                   chip_select_bit1,
  input  wire                   chip_select_bit2,
  input  wire                   write_protect,
  // Array read port, same clock
  output wire [`TWE_ADDR_W-1:0] rd_addr,
  input  wire [7:0]             rd_data,
  // Array write stream
  output wire                   wr_valid,
  input  wire                   wr_ready,
  output wire [`TWE_ADDR_W-1:0] wr_addr,
  output wire [7:0]             wr_data,
  // Status
  output wire                   busy
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX   = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_TX   = 3'h3;
  localparam [2:0] ST_MACK = 3'h4;

  localparam       FW        = `TWE_ADDR_W + 8;
  localparam [19:0] PROG_LAST = PROG_CYCLES[19:0] - 20'h0_0001;

  // Synchronised pins; the bus lines reset high as their pull-ups would.
  wire [5:0] pins_s;
  twe_sync #(
    .WIDTH   (6),
    .RST_VAL (6'h03)
  ) i_twe_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    ({chip_select_bit2, chip_select_bit1, chip_select_bit0, write_protect, scl, sda_in}),
    .sync   (pins_s)
  );

  wire       sda_s = pins_s[0];
  wire       scl_s = pins_s[1];
  wire       wp_s  = pins_s[2];
  wire [2:0] sel_s = pins_s[5:3];

  reg                   scl_d_ff;
  reg                   sda_d_ff;
  reg [2:0]             state_ff;
  reg [3:0]             bit_cnt_ff;
  reg [1:0]             byte_idx_ff;
  reg [7:0]             shift_ff;
  reg [7:0]             tx_ff;
  reg                   rw_ff;
  reg [`TWE_ADDR_W-1:0] addr_ff;
  reg                   sda_oe_ff;
  reg                   sda_out_ff;
  reg                   mack_ff;
  reg                   wr_pend_ff;
  reg                   busy_ff;
  reg [19:0]            prog_cnt_ff;
  reg                   wr_valid_ff;
  reg [`TWE_ADDR_W-1:0] wr_addr_ff;
  reg [7:0]             wr_data_ff;

  reg [2:0]             nxt_state;
  reg [3:0]             nxt_bit_cnt;
  reg [1:0]             nxt_byte_idx;
  reg [7:0]             nxt_shift;
  reg [7:0]             nxt_tx;
  reg                   nxt_rw;
  reg [`TWE_ADDR_W-1:0] nxt_addr;
  reg                   nxt_sda_oe;
  reg                   nxt_mack;
  reg                   nxt_wr_pend;
  reg                   nxt_busy;
  reg [19:0]            nxt_prog_cnt;
  reg                   push;

  // Edges and bus conditions from the second-stage samples only.
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  wire type_ok  = (shift_ff[`TWE_TYPE_MSB:`TWE_TYPE_LSB] == TYPE_CODE);
  wire sel_ok   = (shift_ff[`TWE_SEL_MSB:`TWE_SEL_LSB] == sel_s);
  // Only a driven high level protects.
  wire protect  = (wp_s == 1'b1);

  wire             fifo_in_ready;
  wire             fifo_out_valid;
  wire [FW-1:0]    fifo_out_data;
  wire             fifo_pop = fifo_out_valid & (~wr_valid_ff | wr_ready);

  twe_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) i_twe_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({addr_ff, shift_ff}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  always @* begin
    nxt_state    = state_ff;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_byte_idx = byte_idx_ff;
    nxt_shift    = shift_ff;
    nxt_tx       = tx_ff;
    nxt_rw       = rw_ff;
    nxt_addr     = addr_ff;
    nxt_sda_oe   = sda_oe_ff;
    nxt_mack     = mack_ff;
    nxt_wr_pend  = wr_pend_ff;
    nxt_busy     = busy_ff;
    nxt_prog_cnt = prog_cnt_ff;
    push         = 1'b0;

    // Program timer counts up through the fixed cycle.
    if (busy_ff) begin
      nxt_prog_cnt = prog_cnt_ff + 20'h0_0001;
      if (prog_cnt_ff == PROG_LAST) begin
        nxt_busy = 1'b0;
      end
    end

    if (stop_c) begin
      nxt_state  = ST_IDLE;
      nxt_sda_oe = 1'b0;
      // Accepted data starts the program cycle.
      if (wr_pend_ff) begin
        nxt_busy     = 1'b1;
        nxt_prog_cnt = 20'h0_0000;
        nxt_wr_pend  = 1'b0;
      end
    end else if (start_c) begin
      nxt_sda_oe = 1'b0;
      if (busy_ff) begin
        nxt_state = ST_IDLE;
      end else begin
        nxt_state    = ST_RX;
        nxt_bit_cnt  = 4'h0;
        nxt_byte_idx = `TWE_BYTE_SLAVE;
      end
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_sda_oe = 1'b0;
        end
        ST_RX: begin
          if (scl_rise && bit_cnt_ff != `TWE_BITS_PER_BYTE) begin
            nxt_shift   = {shift_ff[6:0], sda_s};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == `TWE_BITS_PER_BYTE) begin
            nxt_state = ST_ACK;
            case (byte_idx_ff)
              `TWE_BYTE_SLAVE: begin
                // Slave address byte decode, no match while busy.
                if (type_ok && sel_ok && !busy_ff) begin
                  nxt_sda_oe   = 1'b1;
                  nxt_rw       = shift_ff[`TWE_RW_BIT];
                  nxt_byte_idx = `TWE_BYTE_ADDR_HI;
                end else begin
                  nxt_state = ST_IDLE;
                end
              end
              `TWE_BYTE_ADDR_HI: begin
                nxt_sda_oe   = 1'b1;
                nxt_addr     = {shift_ff[`TWE_ADDR_HI_BITS-1:0], addr_ff[7:0]};
                nxt_byte_idx = `TWE_BYTE_ADDR_LO;
              end
              `TWE_BYTE_ADDR_LO: begin
                nxt_sda_oe   = 1'b1;
                nxt_addr     = {addr_ff[`TWE_ADDR_W-1:8], shift_ff};
                nxt_byte_idx = `TWE_BYTE_DATA;
              end
              default: begin
                // Protected or full: no data acknowledge.
                if (!protect && fifo_in_ready) begin
                  nxt_sda_oe  = 1'b1;
                  push        = 1'b1;
                  nxt_wr_pend = 1'b1;
                  nxt_addr    = addr_ff + `TWE_ADDR_ONE;
                end else begin
                  nxt_state = ST_IDLE;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt_sda_oe  = 1'b0;
            nxt_bit_cnt = 4'h0;
            if (rw_ff) begin
              nxt_state  = ST_TX;
              nxt_tx     = rd_data;
              nxt_sda_oe = ~rd_data[7];
              nxt_addr   = addr_ff + `TWE_ADDR_ONE;
            end else begin
              nxt_state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == `TWE_LAST_TX_BIT) begin
              nxt_sda_oe = 1'b0;
              nxt_state  = ST_MACK;
            end else begin
              nxt_tx     = {tx_ff[6:0], 1'b0};
              nxt_sda_oe = ~tx_ff[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            nxt_mack = sda_s;
          end else if (scl_fall) begin
            nxt_bit_cnt = 4'h0;
            if (!mack_ff) begin
              nxt_state  = ST_TX;
              nxt_tx     = rd_data;
              nxt_sda_oe = ~rd_data[7];
              nxt_addr   = addr_ff + `TWE_ADDR_ONE;
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        default: begin
          nxt_state  = ST_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end

    // No drive at all during the program cycle.
    if (nxt_busy) begin
      nxt_sda_oe = 1'b0;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
      state_ff    <= ST_IDLE;
      bit_cnt_ff  <= 4'h0;
      byte_idx_ff <= `TWE_BYTE_SLAVE;
      shift_ff    <= 8'h00;
      tx_ff       <= 8'h00;
      rw_ff       <= 1'b0;
      addr_ff     <= {`TWE_ADDR_W{1'b0}};
      sda_oe_ff   <= 1'b0;
      sda_out_ff  <= 1'b0;
      mack_ff     <= 1'b1;
      wr_pend_ff  <= 1'b0;
      busy_ff     <= 1'b0;
      prog_cnt_ff <= 20'h0_0000;
    end else begin
      scl_d_ff    <= scl_s;
      sda_d_ff    <= sda_s;
      state_ff    <= nxt_state;
      bit_cnt_ff  <= nxt_bit_cnt;
      byte_idx_ff <= nxt_byte_idx;
      shift_ff    <= nxt_shift;
      tx_ff       <= nxt_tx;
      rw_ff       <= nxt_rw;
      addr_ff     <= nxt_addr;
      sda_oe_ff   <= nxt_sda_oe;
      // Open drain: the driven level is always low.
      sda_out_ff  <= 1'b0;
      mack_ff     <= nxt_mack;
      wr_pend_ff  <= nxt_wr_pend;
      busy_ff     <= nxt_busy;
      prog_cnt_ff <= nxt_prog_cnt;
    end
  end

  // Output stage keeps the write stream straight from flops.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_valid_ff <= 1'b0;
      wr_addr_ff  <= {`TWE_ADDR_W{1'b0}};
      wr_data_ff  <= 8'h00;
    end else if (fifo_pop) begin
      wr_valid_ff <= 1'b1;
      wr_addr_ff  <= fifo_out_data[FW-1:8];
      wr_data_ff  <= fifo_out_data[7:0];
    end else if (wr_ready) begin
      wr_valid_ff <= 1'b0;
    end
  end

  assign sda_out  = sda_out_ff;
  assign sda_oe   = sda_oe_ff;
  assign rd_addr  = addr_ff;
  assign wr_valid = wr_valid_ff;
  assign wr_addr  = wr_addr_ff;
  assign wr_data  = wr_data_ff;
  assign busy     = busy_ff;

endmodule

// ### tb/twe_bus_master.sv
// Bus master model that drives the two-wire clock and data lines.
`timescale 1ns/1ns
module twe_bus_master (
  // Reference clock
  input  wire logic clk,
  // Bus lines
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  // Quarter of the 80 ns bit time; each phase spans two slave clocks.
  localparam int QTR = 20;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic bit_cyc(input logic b, output logic s);
    sda_m = b;
    #QTR;
    scl = 1'b1;
    #QTR;
    s = sda;
    #QTR;
    scl = 1'b0;
    #QTR;
  endtask
  task automatic start;
    @(posedge clk);
    #1;
    sda_m = 1'b1;
    #QTR;
    scl = 1'b1;
    #QTR;
    sda_m = 1'b0;
    #QTR;
    scl = 1'b0;
    #QTR;
  endtask
  task automatic stop;
    sda_m = 1'b0;
    #QTR;
    scl = 1'b1;
    #QTR;
    sda_m = 1'b1;
    #QTR;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
    bit_cyc(1'b1, s);
    ack = (s === 1'b0);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
    bit_cyc(nack, s);
  endtask
endmodule

// ### tb/twe_slave_assertions.sv
// Concurrent checks on the ports of the two-wire slave.
`timescale 1ns/1ns
`include "twe_regs.vh"
module twe_slave_assertions #(
  parameter PROG_CYCLES = 200
) (
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire logic                   scl,
  input wire logic                   sda_in,
  input wire logic                   sda_out,
  input wire logic                   sda_oe,
  input wire logic                   write_protect,
  input wire logic                   wr_valid,
  input wire logic                   wr_ready,
  input wire logic [`TWE_ADDR_W-1:0] wr_addr,
  input wire logic [7:0]             wr_data,
  input wire logic                   busy
);
  logic [31:0] busy_run_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_run_ff <= 32'h0000_0000;
    end else begin
      busy_run_ff <= busy ? busy_run_ff + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  a_drive_low_only: assert property (sda_out == 1'b0)
    else $error("Data line driven high.");
  a_busy_quiet: assert property (busy && $past(busy) |-> !sda_oe)
    else $error("Data line pulled while busy.");
  a_edge_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("Data line moved with clock high.");
  a_ack_hold: assert property ($rose(sda_oe) |-> sda_oe[*8])
    else $error("Pull released too early.");
  a_ack_in_high: assert property ($rose(sda_oe) |-> ##[1:14] scl)
    else $error("Pull not seen by a clock high.");
  a_prog_start: assert property ($rose(busy) |-> scl && sda_in)
    else $error("Program cycle began off a stop.");
  a_busy_bound: assert property (busy_run_ff <= PROG_CYCLES)
    else $error("Program cycle too long.");
  a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("Write word changed while stalled.");
  a_protect_blocks: assert property ($rose(wr_valid) |-> !write_protect)
    else $error("Write word under protection.");
  c_prog: cover property ($rose(busy));
  c_stall: cover property (wr_valid && !wr_ready);
  c_prot_ack: cover property ($rose(sda_oe) && write_protect);
endmodule
bind twe_slave twe_slave_assertions #(
  .PROG_CYCLES(PROG_CYCLES)
) i_twe_slave_assertions (
  .clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .write_protect(write_protect), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
  .wr_data(wr_data), .busy(busy)
);

// ### tb/twe_slave_tb_top.sv
// Self-checking bench for the two-wire serial memory slave.
`timescale 1ns/1ns
`include "twe_regs.vh"
module twe_slave_tb_top;
  localparam int         PROG = 300;
  localparam int         LIM  = 2000;
  // Type field matches the design's default type code; select bits match the straps.
  localparam logic [7:0] SA_W = 8'h5A;
  localparam logic [7:0] SA_R = 8'h5B;
  logic        clk;
  logic        arst_n;
  logic        wp;
  logic        wr_ready;
  logic        sda_oe;
  logic        busy;
  logic        wr_valid;
  logic [13:0] rd_addr;
  logic [13:0] wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  mem [0:16383];
  logic [21:0] wq [$];
  int          error_cnt;
  int          cmp_count;
  wire         scl;
  wire         sda_m;
  // Pull-up wins unless either side pulls low.
  wire         sda = sda_m & ~sda_oe;
  wire [7:0]   rd_data = mem[rd_addr];
  twe_slave #(.PROG_CYCLES(PROG)) i_twe_slave (
    .clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .chip_select_bit0(1'b1), .chip_select_bit1(1'b0), .chip_select_bit2(1'b1), .write_protect(wp),
    .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy)
  );
  twe_bus_master i_twe_bus_master (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready) begin
      mem[wr_addr] <= wr_data;
      wq.push_back({wr_addr, wr_data});
    end
  end
  task automatic finish_test;
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Waits for the program cycle to end, or for n stream words.
  task automatic wait_for(input logic idle, input int n);
    int k;
    k = 0;
    while ((idle ? busy !== 1'b0 : wq.size() < n) && k < LIM) begin
      @(posedge clk);
      k++;
    end
    if (k >= LIM) begin
      error_cnt++;
      finish_test();
    end
  endtask
  task automatic addr_phase(input logic [7:0] hi, input logic [7:0] lo, output logic ok);
    logic a0, a1, a2;
    i_twe_bus_master.start();
    i_twe_bus_master.wr_byte(SA_W, a0);
    i_twe_bus_master.wr_byte(hi, a1);
    i_twe_bus_master.wr_byte(lo, a2);
    ok = a0 & a1 & a2;
  endtask
  task automatic poll(output logic a);
    i_twe_bus_master.start();
    i_twe_bus_master.wr_byte(SA_W, a);
    i_twe_bus_master.stop();
  endtask
  task automatic t_write;
    logic a, b, c;
    wq.delete();
    addr_phase(8'hC3, 8'hFE, a);
    i_twe_bus_master.wr_byte(8'hA5, b);
    i_twe_bus_master.wr_byte(8'h5A, c);
    i_twe_bus_master.stop();
    check({a, b, c}, 3'h7);
    wait_for(1'b0, 2);
    check(wq[0], {14'h03FE, 8'hA5});
    check(wq[1], {14'h03FF, 8'h5A});
    poll(a);
    check({a, busy}, 2'h1);
    wait_for(1'b1, 0);
    poll(a);
    check(a, 1'b1);
  endtask
  task automatic t_read;
    logic       a, b;
    logic [7:0] d0, d1;
    addr_phase(8'h03, 8'hFE, a);
    i_twe_bus_master.start();
    i_twe_bus_master.wr_byte(SA_R, b);
    i_twe_bus_master.rd_byte(1'b0, d0);
    i_twe_bus_master.rd_byte(1'b1, d1);
    i_twe_bus_master.stop();
    check({a, b}, 2'h3);
    check({d0, d1}, 16'hA55A);
    check(busy, 1'b0);
  endtask
  task automatic t_mismatch;
    logic a, b;
    for (int i = 0; i < 7; i++) begin
      i_twe_bus_master.start();
      i_twe_bus_master.wr_byte(SA_W ^ (8'h80 >> i), a);
      i_twe_bus_master.wr_byte(SA_W, b);
      i_twe_bus_master.stop();
      if (i < 4) check(a, 1'b0);
      else check(a, 1'b0);
      check(b, 1'b0);
    end
  endtask
  task automatic t_protect;
    logic       a, b;
    logic [7:0] d;
    wq.delete();
    @(posedge clk);
    #1 wp = 1'b1;
    addr_phase(8'h03, 8'hFE, a);
    i_twe_bus_master.wr_byte(8'h3C, b);
    i_twe_bus_master.stop();
    check({a, b}, 2'h2);
    repeat (20) @(posedge clk);
    check({busy, wq.size() != 0}, 2'h0);
    i_twe_bus_master.start();
    i_twe_bus_master.wr_byte(SA_R, a);
    i_twe_bus_master.rd_byte(1'b1, d);
    i_twe_bus_master.stop();
    check({a, d}, 9'h1A5);
    @(posedge clk);
    #1 wp = 1'b0;
  endtask
  task automatic t_fifo;
    logic       a;
    logic [5:0] ak;
    wq.delete();
    @(posedge clk);
    #1 wr_ready = 1'b0;
    addr_phase(8'h01, 8'h00, a);
    for (int i = 0; i < 6; i++) i_twe_bus_master.wr_byte(8'(8'h40 + i), ak[i]);
    i_twe_bus_master.stop();
    check({a, ak}, 7'h5F);
    @(posedge clk);
    #1 wr_ready = 1'b1;
    wait_for(1'b0, 5);
    check(wq[4], {14'h0104, 8'h44});
    wait_for(1'b1, 0);
  endtask
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    wp = 1'b0;
    wr_ready = 1'b1;
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (5) @(posedge clk);
    t_write();
    t_read();
    t_mismatch();
    t_protect();
    t_fifo();
    finish_test();
  end
endmodule
